// [design/adsc_pkg.sv]
// package: register map, field positions, reset values and timing of the converter sequencer
package adsc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL2_OFS = 8'h08;
    localparam logic [7:0] CTRL3_OFS = 8'h0c;
    localparam logic [7:0] CTRL4_OFS = 8'h10;
    localparam logic [7:0] CTRL5_OFS = 8'h14;
    localparam logic [7:0] STAT_OFS = 8'h18;
    localparam logic [7:0] MASK_OFS = 8'h1c;
    localparam logic [7:0] TEST_OFS = 8'h20;
    localparam logic [7:0] RES_OFS = 8'h24;
    // control 2 fields
    localparam int JUSTIFY_POS = 7;
    localparam int SIGNED_POS = 6;
    // control 3 fields
    localparam int FIFO_POS = 1;
    localparam int SINGLE_POS = 0;
    // control 4: settle time in cycles before each conversion, in the low byte
    localparam int CT_W = 8;
    // control 5 fields
    localparam int SCAN_POS = 5;
    localparam int MULT_POS = 4;
    localparam int REFSEL_POS = 7;
    localparam int LEN8_POS = 6;
    localparam int CHB2_POS = 2;
    localparam int CHB1_POS = 1;
    localparam int CHB0_POS = 0;
    // status bits: done flag and conversion-complete flag
    localparam int DONE_POS = 0;
    localparam int CCF_POS = 1;
    // test register reset bit
    localparam int TRST_POS = 0;
    // reset values giving legacy behaviour
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CTRL3_RST = 8'h00;
    localparam logic [7:0] CTRL4_RST = 8'h07;
    localparam logic [7:0] CTRL5_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    // sar width and number of sar steps
    localparam int SAR_W = 10;
    localparam logic [3:0] SAR_STEPS = 4'ha;
    // legacy sequence length of four, eight when the length bit is set
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [3:0] LEN_FOUR = 4'h4;
    localparam logic [3:0] LEN_EIGHT = 4'h8;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} adsc_state_t;
endpackage : adsc_pkg

// [design/adsc_sar.sv]
// one successive approximation conversion against an external comparator
`timescale 1ns/1ps
module adsc_sar
    import adsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic abort,
    input wire logic cmpHigh,
    output logic [SAR_W-1:0] sarVal,
    output logic busy,
    output logic done
);
    logic [SAR_W-1:0] sar_ff;
    logic [SAR_W-1:0] bit_ff;
    logic busy_ff;
    logic done_ff;

    // bit trial: keep the trial bit when the comparator says input is above the dac
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || abort)
        begin
            sar_ff <= '0;
            bit_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else if (start)
        begin
            sar_ff <= {1'b1, {(SAR_W-1){1'b0}}};
            bit_ff <= {1'b1, {(SAR_W-1){1'b0}}};
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end
        else if (busy_ff)
        begin
            sar_ff <= (cmpHigh ? sar_ff : (sar_ff & ~bit_ff)) | (bit_ff >> 1);
            bit_ff <= bit_ff >> 1;
            busy_ff <= (bit_ff != {{(SAR_W-1){1'b0}}, 1'b1});
            done_ff <= (bit_ff == {{(SAR_W-1){1'b0}}, 1'b1});
        end
        else
        begin
            done_ff <= 1'b0;
        end
    end

    assign sarVal = sar_ff;
    assign busy = busy_ff;
    assign done = done_ff;
endmodule : adsc_sar

// [design/adsc_fmt.sv]
// result formatting: justification and signed offset
`timescale 1ns/1ps
module adsc_fmt
    import adsc_pkg::*;
(
    input wire logic [SAR_W-1:0] raw,
    input wire logic justifyRight,
    input wire logic signedOut,
    output logic [15:0] result
);
    logic [SAR_W-1:0] val;

    // signed mode flips the msb so mid-scale reads as zero
    always_comb
    begin
        val = raw ^ {signedOut, {(SAR_W-1){1'b0}}};
        if (justifyRight)
            result = {{(16-SAR_W){signedOut & val[SAR_W-1]}}, val};
        else
            result = {val, {(16-SAR_W){1'b0}}};
    end
endmodule : adsc_fmt

// [design/adsc_seq_ctrl.sv]
// converter sequence control with apb register file and interrupt
// Overview of operation
// - the three channel bits choose the first channel of a multi-channel sequence
// - top channel bit stays in effect unless eight-conversion length is set
// - reference select bit converts internal references instead of external inputs
// - control two holds justify and signed bits, reset gives legacy unsigned format
// - control three holds fifo placement and single bits, reset gives legacy
// - single-conversion bit modifies sequence length; default keeps legacy length
// - any write to control four aborts and restarts the sequence
// - writes to control two or three do not abort a running sequence
// - write to control five aborts, clears completion flags, starts new sequence
// - in scan mode the done flag sets after every sequence
// - reading the test register returns the live sar contents
// - the test reset bit is writable and resets the converter logic
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module adsc_seq_ctrl
    import adsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpHigh,
    output logic [3:0] muxSel,
    output logic refSel,
    output logic irq
);
    logic [7:0] ctrl2_ff;
    logic [7:0] ctrl3_ff;
    logic [7:0] ctrl4_ff;
    logic [7:0] ctrl5_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    logic [2:0] chan_ff;
    logic [3:0] cnt_ff;
    logic [2:0] slot_ff;
    logic [2:0] lastSlot_ff;
    logic [CT_W-1:0] wait_ff;
    logic [15:0] res_ff [8];
    logic [31:0] prdata_ff;
    logic cmpSync1_ff;
    logic cmpSync2_ff;
    adsc_state_t state_ff;
    logic wrEn;
    logic rdEn;
    logic restart;
    logic convRst;
    logic sarStart;
    logic sarBusy;
    logic sarDone;
    logic [SAR_W-1:0] sarVal;
    logic [15:0] fmtRes;
    logic [3:0] seqLen;
    logic lastConv;
    logic [2:0] nextChan;

    // address decode helper shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    // zero wait state slave; unmapped addresses flag an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit(paddr, CTRL2_OFS) || hit(paddr, CTRL3_OFS)
        || hit(paddr, CTRL4_OFS) || hit(paddr, CTRL5_OFS) || hit(paddr, STAT_OFS)
        || hit(paddr, MASK_OFS) || hit(paddr, TEST_OFS) || hit(paddr, RES_OFS));

    // restart on control four or five writes; control two and three never abort
    assign restart = wrEn && (hit(paddr, CTRL4_OFS) || hit(paddr, CTRL5_OFS));
    assign convRst = wrEn && hit(paddr, TEST_OFS) && pwdata[TRST_POS];

    // comparator comes from the analog side, so synchronise it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cmpSync1_ff <= 1'b0;
            cmpSync2_ff <= 1'b0;
        end
        else
        begin
            cmpSync1_ff <= cmpHigh;
            cmpSync2_ff <= cmpSync1_ff;
        end
    end

    // configuration registers; reset values give legacy behaviour
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl2_ff <= CTRL2_RST;
            ctrl3_ff <= CTRL3_RST;
            ctrl4_ff <= CTRL4_RST;
            ctrl5_ff <= CTRL5_RST;
            mask_ff <= MASK_RST;
        end
        else if (wrEn)
        begin
            if (hit(paddr, CTRL2_OFS))
                ctrl2_ff <= pwdata[7:0];
            if (hit(paddr, CTRL3_OFS))
                ctrl3_ff <= pwdata[7:0];
            if (hit(paddr, CTRL4_OFS))
                ctrl4_ff <= pwdata[7:0];
            if (hit(paddr, CTRL5_OFS))
                ctrl5_ff <= pwdata[7:0];
            if (hit(paddr, MASK_OFS))
                mask_ff <= pwdata[1:0];
        end
    end

    // single bit overrides to one conversion, else legacy four or eight
    assign seqLen = ctrl3_ff[SINGLE_POS] ? LEN_ONE
        : (ctrl5_ff[LEN8_POS] ? LEN_EIGHT : LEN_FOUR);
    // at or past the length, so a mid-sequence switch to single cannot run the count away
    assign lastConv = (cnt_ff + 4'h1 >= seqLen);
    // wrap inside group: whole eight in long mode, four-group otherwise
    always_comb
    begin
        if (ctrl5_ff[LEN8_POS])
            nextChan = chan_ff + 3'h1;
        else
            nextChan = {chan_ff[2], chan_ff[1:0] + 2'h1};
    end

    // sequencer: settle time from control four, then one sar conversion
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || convRst)
        begin
            state_ff <= ST_IDLE;
            chan_ff <= '0;
            cnt_ff <= '0;
            slot_ff <= '0;
            wait_ff <= '0;
        end
        else if (restart)
        begin
            state_ff <= ST_CONV;
            // first channel taken unmasked from the channel bits
            chan_ff <= (hit(paddr, CTRL5_OFS) ? pwdata[2:0] : ctrl5_ff[2:0]);
            cnt_ff <= '0;
            slot_ff <= '0;
            wait_ff <= (hit(paddr, CTRL4_OFS) ? pwdata[CT_W-1:0] : ctrl4_ff);
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    state_ff <= ST_IDLE;
                ST_CONV:
                    if (wait_ff != '0)
                        wait_ff <= wait_ff - 8'h01;
                    else if (sarDone)
                        state_ff <= ST_STORE;
                ST_STORE:
                begin
                    // fifo mode keeps rolling slot, legacy resets each sequence
                    slot_ff <= slot_ff + 3'h1;
                    wait_ff <= ctrl4_ff;
                    if (ctrl5_ff[MULT_POS])
                        chan_ff <= nextChan;
                    if (lastConv)
                    begin
                        cnt_ff <= '0;
                        if (!ctrl3_ff[FIFO_POS])
                            slot_ff <= '0;
                        state_ff <= ctrl5_ff[SCAN_POS] ? ST_CONV : ST_IDLE;
                        if (ctrl5_ff[SCAN_POS] && ctrl5_ff[MULT_POS])
                            chan_ff <= ctrl5_ff[2:0];
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff + 4'h1;
                        state_ff <= ST_CONV;
                    end
                end
            endcase
        end
    end

    assign sarStart = (state_ff == ST_CONV) && (wait_ff == '0) && !sarBusy && !sarDone;

    adsc_sar u_sar (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(sarStart),
        .abort(restart || convRst),
        .cmpHigh(cmpSync2_ff),
        .sarVal(sarVal),
        .busy(sarBusy),
        .done(sarDone)
    );

    // control two is read live, so mid-sequence changes take effect
    adsc_fmt u_fmt (
        .raw(sarVal),
        .justifyRight(ctrl2_ff[JUSTIFY_POS]),
        .signedOut(ctrl2_ff[SIGNED_POS]),
        .result(fmtRes)
    );

    // result store; the written slot is kept so a read returns the newest result
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 8; i++)
                res_ff[i] <= '0;
            lastSlot_ff <= '0;
        end
        else if (state_ff == ST_STORE)
        begin
            res_ff[slot_ff] <= fmtRes;
            lastSlot_ff <= slot_ff;
        end
    end

    // sticky status; set wins over read-clear, but a control five restart clears all
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || convRst)
        begin
            stat_ff <= '0;
        end
        else
        begin
            if (wrEn && hit(paddr, CTRL5_OFS))
                stat_ff <= '0;
            else if (rdEn && hit(paddr, STAT_OFS))
                stat_ff <= '0;
            if (state_ff == ST_STORE && !(wrEn && hit(paddr, CTRL5_OFS)))
                stat_ff[CCF_POS] <= 1'b1;
            if (state_ff == ST_STORE && lastConv && !(wrEn && hit(paddr, CTRL5_OFS)))
                stat_ff[DONE_POS] <= 1'b1;
        end
    end

    assign irq = |(stat_ff & mask_ff);

    // read data registered in the setup phase, ready for the access phase
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            prdata_ff <= '0;
        else if (psel && !penable && !pwrite)
        begin
            prdata_ff <= '0;
            if (hit(paddr, CTRL2_OFS))
                prdata_ff <= {24'h000000, ctrl2_ff};
            if (hit(paddr, CTRL3_OFS))
                prdata_ff <= {24'h000000, ctrl3_ff};
            if (hit(paddr, CTRL4_OFS))
                prdata_ff <= {24'h000000, ctrl4_ff};
            if (hit(paddr, CTRL5_OFS))
                prdata_ff <= {24'h000000, ctrl5_ff};
            if (hit(paddr, STAT_OFS))
                prdata_ff <= {30'h00000000, stat_ff};
            if (hit(paddr, MASK_OFS))
                prdata_ff <= {30'h00000000, mask_ff};
            if (hit(paddr, TEST_OFS))
                prdata_ff <= {{(32-SAR_W){1'b0}}, sarVal};
            if (hit(paddr, RES_OFS))
                prdata_ff <= {16'h0000, res_ff[lastSlot_ff]};
        end
    end
    assign prdata = prdata_ff;

    // analog mux: reference select picks internal sources
    assign refSel = ctrl5_ff[REFSEL_POS];
    assign muxSel = {ctrl5_ff[REFSEL_POS], chan_ff};

    // checks
    property p_done_seq;
        @(posedge core_clk) disable iff (sys_rst)
        (state_ff == ST_STORE && lastConv && !convRst && !restart) |=> stat_ff[DONE_POS];
    endproperty
    a_done_seq: assert property (p_done_seq) else $error("done flag missing");

    property p_ctl5_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (wrEn && hit(paddr, CTRL5_OFS)) |=> (state_ff == ST_CONV && stat_ff == 2'h0);
    endproperty
    a_ctl5_clear: assert property (p_ctl5_clear) else $error("control five restart failed");

    property p_ctl4_restart;
        @(posedge core_clk) disable iff (sys_rst)
        (wrEn && hit(paddr, CTRL4_OFS) && !convRst) |=> (state_ff == ST_CONV && cnt_ff == 4'h0);
    endproperty
    a_ctl4_restart: assert property (p_ctl4_restart) else $error("control four restart failed");

    property p_cfg_noabort;
        @(posedge core_clk) disable iff (sys_rst)
        (wrEn && (hit(paddr, CTRL2_OFS) || hit(paddr, CTRL3_OFS)) && state_ff == ST_CONV)
        |=> state_ff != ST_IDLE;
    endproperty
    a_cfg_noabort: assert property (p_cfg_noabort) else $error("config write aborted");

    property p_first_chan;
        @(posedge core_clk) disable iff (sys_rst)
        (wrEn && hit(paddr, CTRL5_OFS) && !convRst) |=> chan_ff == $past(pwdata[2:0]);
    endproperty
    a_first_chan: assert property (p_first_chan) else $error("first channel masked");

    property p_ref_sel;
        @(posedge core_clk) disable iff (sys_rst)
        (wrEn && hit(paddr, CTRL5_OFS) && !convRst)
        |=> (refSel == $past(pwdata[REFSEL_POS]) && muxSel[3] == refSel);
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");

    property p_single_len;
        @(posedge core_clk) disable iff (sys_rst)
        (state_ff == ST_STORE && ctrl3_ff[SINGLE_POS]) |-> lastConv;
    endproperty
    a_single_len: assert property (p_single_len) else $error("single length wrong");

    property p_test_rst;
        @(posedge core_clk) disable iff (sys_rst)
        convRst |=> (state_ff == ST_IDLE && stat_ff == 2'h0);
    endproperty
    a_test_rst: assert property (p_test_rst) else $error("test reset ignored");

    property p_irq;
        @(posedge core_clk) disable iff (sys_rst)
        (state_ff == ST_STORE && lastConv && mask_ff[DONE_POS] && !restart && !convRst
        && !(wrEn && hit(paddr, MASK_OFS))) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");
endmodule : adsc_seq_ctrl

// [bench/adsc_seq_ctrl_tb.sv]
// self-checking bench for the converter sequence control block
`timescale 1ns/1ps
module adsc_seq_ctrl_tb
    import adsc_pkg::*;
;
    logic core_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmpHigh;
    logic [3:0] muxSel;
    logic refSel;
    logic irq;
    int miscompares;
    int nTests;
    int seed;
    int cnt;
    int ch;
    int l8;
    int rs;
    logic [31:0] rd;
    logic err;
    int chQ[$];
    logic [7:0] rstOfs [5];
    logic [7:0] rstVal [5];

    // free-running core clock, 100 MHz
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    adsc_seq_ctrl u_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cmpHigh(cmpHigh),
        .muxSel(muxSel),
        .refSel(refSel),
        .irq(irq)
    );

    // compare and count; case inequality so unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // single exit point for normal end and watchdog
    task automatic results;
        $display("checks %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // apb master: setup then access held until pready is seen at an edge
    task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50)
            miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apbXfer

    // wait for the mux to move on; comparator toggles randomly meanwhile
    task automatic waitMux(input int bound);
        logic [3:0] last;
        int k;
        last = muxSel;
        k = 0;
        while (muxSel === last && k < bound)
        begin
            @(posedge core_clk);
            cmpHigh <= 1'($random(seed));
            #1;
            k++;
        end
    endtask : waitMux

    // wait for the interrupt line, bounded; cnt tells how long it took
    task automatic waitIrq(input int bound);
        cnt = 0;
        while (irq !== 1'b1 && cnt < bound)
        begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask : waitIrq

    // reference model of channel stepping: wrap in group of four unless eight-long
    function automatic int nextCh(input int c, input int eight);
        return eight ? ((c + 1) & 7) : ((c & 4) | ((c + 1) & 3));
    endfunction : nextCh

    // watchdog sized well above the expected run of a few thousand cycles
    initial
    begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        results();
    end

    // main sequence
    initial
    begin
        seed = 32'hb427;
        miscompares = 0;
        nTests = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmpHigh = 1'b0;
        rstOfs = '{CTRL2_OFS, CTRL3_OFS, CTRL4_OFS, CTRL5_OFS, MASK_OFS};
        rstVal = '{CTRL2_RST, CTRL3_RST, CTRL4_RST, CTRL5_RST, 8'h00};
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        check("muxSel", {28'h0, muxSel}, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            apbXfer(1'b0, rstOfs[i], 32'h0);
            check("reset value", rd, {24'h0, rstVal[i]});
        end
        apbXfer(1'b0, 8'h40, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apbXfer(1'b1, MASK_OFS, 32'h1);
        apbXfer(1'b1, CTRL4_OFS, 32'h2);
        // random first channel, length and reference select against the model queue
        for (int i = 0; i < 8; i++)
        begin
            ch = $random(seed) & 7;
            l8 = i & 1;
            rs = (i == 2 || i == 5) ? 1 : 0;
            if (rs != 0)
                ch = 0;
            apbXfer(1'b1, CTRL5_OFS, 32'(rs * 128 + l8 * 64 + 16 + ch));
            check("first ch", {28'h0, muxSel}, 32'(rs * 8 + ch));
            check("refSel", {31'h0, refSel}, 32'(rs));
            for (int k = 0; k < (l8 ? 7 : 3); k++)
            begin
                ch = nextCh(ch, l8);
                chQ.push_back(rs * 8 + ch);
            end
            while (chQ.size() > 0)
            begin
                waitMux(100);
                check("next ch", {28'h0, muxSel}, 32'(chQ.pop_front()));
            end
            waitIrq(100);
            apbXfer(1'b0, STAT_OFS, 32'h0);
            check("done flag", {31'h0, rd[DONE_POS]}, 32'h1);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        // mid-sequence writes: config keeps running, control four restarts
        apbXfer(1'b1, CTRL5_OFS, 32'h11);
        waitMux(100);
        check("step", {28'h0, muxSel}, 32'h2);
        apbXfer(1'b1, CTRL2_OFS, 32'hc0);
        check("ctrl2 no abort", {28'h0, muxSel}, 32'h2);
        apbXfer(1'b1, CTRL3_OFS, 32'h02);
        check("ctrl3 no abort", {28'h0, muxSel}, 32'h2);
        apbXfer(1'b1, CTRL4_OFS, 32'h2);
        check("ctrl4 restart", {28'h0, muxSel}, 32'h1);
        apbXfer(1'b0, CTRL2_OFS, 32'h0);
        check("ctrl2 rd", rd, 32'hc0);
        apbXfer(1'b0, CTRL3_OFS, 32'h0);
        check("ctrl3 rd", rd, 32'h02);
        apbXfer(1'b1, CTRL2_OFS, 32'h0);
        // single-conversion bit against legacy length of four
        for (int s = 1; s >= 0; s--)
        begin
            apbXfer(1'b1, CTRL3_OFS, 32'(s));
            apbXfer(1'b1, CTRL5_OFS, 32'h15);
            waitIrq(300);
            check("end ch", {28'h0, muxSel}, s ? 32'h6 : 32'h5);
            check("single fast", 32'(cnt <= 30), 32'(s));
            apbXfer(1'b0, STAT_OFS, 32'h0);
        end
        // test register shows the sar: all ones then all zeros
        apbXfer(1'b1, CTRL3_OFS, 32'h1);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge core_clk);
            cmpHigh <= 1'(v);
            apbXfer(1'b1, CTRL5_OFS, 32'h00);
            waitIrq(300);
            apbXfer(1'b0, TEST_OFS, 32'h0);
            check("sar", rd, v ? 32'h3ff : 32'h0);
            apbXfer(1'b0, RES_OFS, 32'h0);
            check("result", rd, v ? 32'hffc0 : 32'h0);
            apbXfer(1'b0, STAT_OFS, 32'h0);
        end
        apbXfer(1'b1, CTRL3_OFS, 32'h0);
        // scan mode flags every sequence; control five clears flags
        apbXfer(1'b1, CTRL5_OFS, 32'h30);
        waitIrq(300);
        apbXfer(1'b0, STAT_OFS, 32'h0);
        check("scan done 1", {31'h0, rd[DONE_POS]}, 32'h1);
        waitIrq(300);
        check("scan done 2", {31'h0, irq}, 32'h1);
        apbXfer(1'b1, CTRL5_OFS, 32'h30);
        apbXfer(1'b0, STAT_OFS, 32'h0);
        check("ctrl5 clears", rd, 32'h0);
        check("irq after ctrl5", {31'h0, irq}, 32'h0);
        // converter reset from the test register stops the scan
        waitIrq(300);
        apbXfer(1'b1, TEST_OFS, 32'h1);
        apbXfer(1'b0, STAT_OFS, 32'h0);
        check("trst status", rd, 32'h0);
        waitIrq(300);
        check("trst idle", {31'h0, irq}, 32'h0);
        // masked event stays sticky and raises irq once unmasked
        apbXfer(1'b1, MASK_OFS, 32'h0);
        apbXfer(1'b1, CTRL5_OFS, 32'h10);
        waitIrq(300);
        check("masked irq", {31'h0, irq}, 32'h0);
        apbXfer(1'b1, MASK_OFS, 32'h1);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        apbXfer(1'b0, STAT_OFS, 32'h0);
        check("sticky done", {31'h0, rd[DONE_POS]}, 32'h1);
        check("irq low", {31'h0, irq}, 32'h0);
        results();
    end
endmodule : adsc_seq_ctrl_tb
